// *** common/vip_pkg.sv ***
// constants for the vectored interrupt prioritizer
// assumes one system clock and a synchronous active-low reset
//
// Function
// (RQ1) sixty-four request channels; every on-chip request maps to one channel
// (RQ2) sources programmed onto the same channel share it; any one raises it
// (RQ3) each channel has its own mask bit
// (RQ4) each channel is classed fast or normal
// (RQ5) non-maskable behaviour is chosen by the processor's own control register
// (RQ6) lowest pending channel number wins
// (RQ7) error unit high-level on channel 0, channel 1 reserved
// (RQ8) os tick timer compares 2-5, overflows 6-7, timebase 8
// (RQ9) error unit low-level on 20, software-triggered interrupt on 21
// (RQ10) high end timer 10/24, its transfer unit 11/25
// (RQ11) serial port 1 on 12/26, port 3 on 37/38, port 5 on 53/56
// (RQ12) lin unit 1 on 13/27, lin unit 2 on 49/54
// (RQ13) converter 1 event, sw1, sw2, magnitude on 14, 15, 28, 31
// (RQ14) converter 2 event, sw1, sw2, magnitude on 50, 51, 57, 59
// (RQ15) can controllers 16/29/44, 35/42/46, 45/55/60
// (RQ16) tt bus 18/32/52/62, its transfer unit 48/58
// (RQ17) data modification unit on 36 and 43
// (RQ18) fast and normal outputs assert for unmasked pending channels, give winning index
// (RQ19) requests are levels sampled each clock; reset restores default map, normal class
package vip_pkg;
    localparam int                 NUM_CH     = 64;
    localparam int                 CH_W       = 6;
    localparam logic [NUM_CH-1:0]  MASK_RST   = 64'h0000_0000_0000_0000;
    localparam logic [NUM_CH-1:0]  CLASS_RST  = 64'h0000_0000_0000_0000;
    localparam logic [CH_W-1:0]    CH_RST     = 6'h00;
    // default source positions; source n lands on channel n after reset
    localparam logic [CH_W-1:0] CH_ESU_HIGH      = 6'h00; // RQ7
    localparam logic [CH_W-1:0] CH_RESERVED_NMI  = 6'h01; // RQ7
    localparam logic [CH_W-1:0] CH_OS_CMP0       = 6'h02; // RQ8
    localparam logic [CH_W-1:0] CH_OS_OVF0       = 6'h06; // RQ8
    localparam logic [CH_W-1:0] CH_OS_TIMEBASE   = 6'h08; // RQ8
    localparam logic [CH_W-1:0] CH_ESU_LOW       = 6'h14; // RQ9
    localparam logic [CH_W-1:0] CH_SW_TRIG       = 6'h15; // RQ9
    localparam logic [CH_W-1:0] CH_HET_L1        = 6'h0a; // RQ10
    localparam logic [CH_W-1:0] CH_HET_L2        = 6'h18; // RQ10
    localparam logic [CH_W-1:0] CH_TTU_L1        = 6'h0b; // RQ10
    localparam logic [CH_W-1:0] CH_SPI1_L0       = 6'h0c; // RQ11
    localparam logic [CH_W-1:0] CH_SPI3_L0       = 6'h25; // RQ11
    localparam logic [CH_W-1:0] CH_SPI5_L1       = 6'h38; // RQ11
    localparam logic [CH_W-1:0] CH_LIN_SERIAL_UNIT_1_L0       = 6'h0d; // RQ12
    localparam logic [CH_W-1:0] CH_LIN_SERIAL_UNIT_2_L1       = 6'h36; // RQ12
    localparam logic [CH_W-1:0] CH_CONV1_EVT     = 6'h0e; // RQ13
    localparam logic [CH_W-1:0] CH_CONV1_MAG     = 6'h1f; // RQ13
    localparam logic [CH_W-1:0] CH_CONV2_EVT     = 6'h32; // RQ14
    localparam logic [CH_W-1:0] CH_CONV2_MAG     = 6'h3b; // RQ14
    localparam logic [CH_W-1:0] CH_CAN1_L0       = 6'h10; // RQ15
    localparam logic [CH_W-1:0] CH_CAN3_IF3      = 6'h3c; // RQ15
    localparam logic [CH_W-1:0] CH_TT_L0         = 6'h12; // RQ16
    localparam logic [CH_W-1:0] CH_TT_TIMER1     = 6'h3e; // RQ16
    localparam logic [CH_W-1:0] CH_TTBU_ERR      = 6'h3a; // RQ16
    localparam logic [CH_W-1:0] CH_DMU_L0        = 6'h24; // RQ17
    localparam logic [CH_W-1:0] CH_DMU_L1        = 6'h2b; // RQ17
endpackage

// *** hdl/vip_top.sv ***
// vectored interrupt prioritizer: 64 level requests in, fast and normal requests out
// assumes requests and configuration ports are synchronous to ref_clk
`timescale 1ns/10ps
module vip_top
    import vip_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // peripheral request lines, one per source
    input  wire logic [NUM_CH-1:0] src_req,
    // source to channel mapping write
    input  wire logic              map_wr_en,
    input  wire logic [CH_W-1:0]   map_wr_src,
    input  wire logic [CH_W-1:0]   map_wr_chan,
    // mapping readback
    input  wire logic [CH_W-1:0]   map_rd_src,
    output logic      [CH_W-1:0]   map_rd_chan_q,
    // channel enable and class writes
    input  wire logic              mask_wr_en,
    input  wire logic [NUM_CH-1:0] mask_wr_data,
    input  wire logic              class_wr_en,
    input  wire logic [NUM_CH-1:0] class_wr_data,
    // configuration and status readback
    output logic      [NUM_CH-1:0] chan_enable_q,
    output logic      [NUM_CH-1:0] chan_fast_q,
    output logic      [NUM_CH-1:0] chan_pend_q,
    // processor side
    output logic                   fast_irq_request_q,
    output logic      [CH_W-1:0]   fast_irq_chan_q,
    output logic                   norm_irq_request_q,
    output logic      [CH_W-1:0]   norm_irq_chan_q
);

    // lowest set bit wins; bit CH_W is the valid flag
    function automatic logic [CH_W:0] prio_find(input logic [NUM_CH-1:0] vec);
        logic [CH_W:0] res;
        res = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                res = {1'b1, CH_W'(i)};
            end
        end
        return res;
    endfunction

    logic [NUM_CH-1:0] req_q;
    logic [NUM_CH-1:0] req_d;
    logic [CH_W-1:0]   map_q [NUM_CH];
    logic [CH_W-1:0]   map_d [NUM_CH];
    logic [NUM_CH-1:0] mask_q;
    logic [NUM_CH-1:0] mask_d;
    logic [NUM_CH-1:0] class_q;
    logic [NUM_CH-1:0] class_d;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] act_fast;
    logic [NUM_CH-1:0] act_norm;
    logic [CH_W:0]     fsel;
    logic [CH_W:0]     nsel;
    logic [CH_W-1:0]   map_rd_chan_d;
    logic [NUM_CH-1:0] chan_pend_d;
    logic              fast_req_d;
    logic [CH_W-1:0]   fast_chan_d;
    logic              norm_req_d;
    logic [CH_W-1:0]   norm_chan_d;

    // configuration next state
    always_comb
    begin
        req_d   = src_req;                              // RQ19
        map_d   = map_q;
        mask_d  = mask_q;
        class_d = class_q;
        if (map_wr_en)
        begin
            map_d[map_wr_src] = map_wr_chan;            // RQ1
        end
        if (mask_wr_en)
        begin
            mask_d = mask_wr_data;                      // RQ3
        end
        if (class_wr_en)
        begin
            class_d = class_wr_data;                    // RQ4
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            req_q   <= '0;
            mask_q  <= MASK_RST;
            class_q <= CLASS_RST;                       // RQ19
            for (int i = 0; i < NUM_CH; i++)
            begin
                map_q[i] <= CH_W'(i);                   // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14 RQ15 RQ16 RQ17
            end
        end
        else
        begin
            req_q   <= req_d;
            mask_q  <= mask_d;
            class_q <= class_d;
            map_q   <= map_d;
        end
    end

    // channel collection and prioritization
    always_comb
    begin
        pend = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (req_q[i])
            begin
                pend[map_q[i]] = 1'b1;                  // RQ2
            end
        end
        act_fast      = pend & mask_q & class_q;        // RQ3 RQ4
        act_norm      = pend & mask_q & ~class_q;
        fsel          = prio_find(act_fast);            // RQ6
        nsel          = prio_find(act_norm);            // RQ6
        fast_req_d    = fsel[CH_W];                     // RQ18
        fast_chan_d   = fsel[CH_W-1:0];
        norm_req_d    = nsel[CH_W];                     // RQ18
        norm_chan_d   = nsel[CH_W-1:0];
        chan_pend_d   = pend;
        map_rd_chan_d = map_q[map_rd_src];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fast_irq_request_q <= 1'b0;
            fast_irq_chan_q    <= CH_RST;
            norm_irq_request_q <= 1'b0;
            norm_irq_chan_q    <= CH_RST;
            chan_pend_q        <= '0;
            map_rd_chan_q      <= CH_RST;
        end
        else
        begin
            fast_irq_request_q <= fast_req_d;
            fast_irq_chan_q    <= fast_chan_d;
            norm_irq_request_q <= norm_req_d;
            norm_irq_chan_q    <= norm_chan_d;
            chan_pend_q        <= chan_pend_d;
            map_rd_chan_q      <= map_rd_chan_d;
        end
    end

    assign chan_enable_q = mask_q;
    assign chan_fast_q   = class_q;

    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_esu_raise;
        src_req[CH_ESU_HIGH] && map_q[CH_ESU_HIGH] == CH_ESU_HIGH && mask_q[CH_ESU_HIGH]
            && !mask_wr_en && !map_wr_en && !class_wr_en;
    endsequence

    sequence s_quiet_cfg;
        !mask_wr_en && !map_wr_en && !class_wr_en;
    endsequence

    AST_FAST_ASSERTS: assert property ((act_fast != '0) |=> fast_irq_request_q) // RQ18
        else $error("fast request missing while a fast channel is pending");

    AST_NORM_IDLE: assert property ((act_norm == '0) |=> !norm_irq_request_q) // RQ18
        else $error("normal request without a pending normal channel");

    localparam logic [NUM_CH-1:0] BIT0 = 64'h0000_0000_0000_0001;

    sequence s_fast_shown;
        fast_irq_request_q;
    endsequence

    sequence s_norm_shown;
        norm_irq_request_q;
    endsequence

    AST_FAST_INDEX: assert property ( // RQ6
        (act_fast != '0) |=> ((($past(act_fast) >> fast_irq_chan_q) & BIT0) != '0)
            && ($past(act_fast) & ((BIT0 << fast_irq_chan_q) - BIT0)) == '0)
        else $error("fast index is not the lowest pending fast channel");

    AST_NORM_LOWEST: assert property (
        norm_irq_request_q |-> ($past(act_norm) & ((64'h0000_0000_0000_0001 << norm_irq_chan_q) - 1)) == '0) // RQ6
        else $error("a lower normal channel was pending but not chosen");

    AST_MASK_ALL_OFF: assert property (
        (mask_q == '0) |=> !fast_irq_request_q && !norm_irq_request_q) // RQ3
        else $error("request passed with every channel disabled");

    AST_RESET_DEFAULT: assert property (
        $past(!rst_n) |-> mask_q == MASK_RST && class_q == CLASS_RST
            && map_q[CH_OS_TIMEBASE] == CH_OS_TIMEBASE && map_q[CH_DMU_L1] == CH_DMU_L1) // RQ19
        else $error("configuration not at default after reset");

    AST_SHARED_PEND: assert property ( // RQ2
        req_q[CH_OS_TIMEBASE] |=> chan_pend_q[$past(map_q[CH_OS_TIMEBASE])])
        else $error("request did not raise its mapped channel");

    AST_MAP_WRITE: assert property (
        map_wr_en |=> map_q[$past(map_wr_src)] == $past(map_wr_chan)) // RQ1
        else $error("mapping write not stored");

    AST_ESU_LATENCY: assert property (
        s_esu_raise ##1 s_quiet_cfg |=> (fast_irq_request_q && fast_irq_chan_q == CH_ESU_HIGH)
            || (norm_irq_request_q && norm_irq_chan_q == CH_ESU_HIGH)) // RQ7
        else $error("channel 0 request not presented two cycles after it rose");

    AST_CLASS_ROUTE: assert property ( // RQ4
        (class_q == '0) |=> !fast_irq_request_q)
        else $error("fast output asserted with every channel in the normal class");

    AST_RESET_MAP: assert property ($past(!rst_n) |-> // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14 RQ15 RQ16 RQ17
        map_q[CH_ESU_HIGH] == CH_ESU_HIGH
        && map_q[CH_RESERVED_NMI] == CH_RESERVED_NMI
        && map_q[CH_OS_CMP0] == CH_OS_CMP0
        && map_q[CH_OS_OVF0] == CH_OS_OVF0
        && map_q[CH_OS_TIMEBASE] == CH_OS_TIMEBASE
        && map_q[CH_ESU_LOW] == CH_ESU_LOW
        && map_q[CH_SW_TRIG] == CH_SW_TRIG
        && map_q[CH_HET_L1] == CH_HET_L1
        && map_q[CH_HET_L2] == CH_HET_L2
        && map_q[CH_TTU_L1] == CH_TTU_L1
        && map_q[CH_SPI1_L0] == CH_SPI1_L0
        && map_q[CH_SPI3_L0] == CH_SPI3_L0
        && map_q[CH_SPI5_L1] == CH_SPI5_L1
        && map_q[CH_LIN_SERIAL_UNIT_1_L0] == CH_LIN_SERIAL_UNIT_1_L0
        && map_q[CH_LIN_SERIAL_UNIT_2_L1] == CH_LIN_SERIAL_UNIT_2_L1
        && map_q[CH_CONV1_EVT] == CH_CONV1_EVT
        && map_q[CH_CONV1_MAG] == CH_CONV1_MAG
        && map_q[CH_CONV2_EVT] == CH_CONV2_EVT
        && map_q[CH_CONV2_MAG] == CH_CONV2_MAG
        && map_q[CH_CAN1_L0] == CH_CAN1_L0
        && map_q[CH_CAN3_IF3] == CH_CAN3_IF3
        && map_q[CH_TT_L0] == CH_TT_L0
        && map_q[CH_TT_TIMER1] == CH_TT_TIMER1
        && map_q[CH_TTBU_ERR] == CH_TTBU_ERR
        && map_q[CH_DMU_L0] == CH_DMU_L0
        && map_q[CH_DMU_L1] == CH_DMU_L1)
        else $error("default source to channel map not restored by reset");

    AST_RESET_OUTPUTS: assert property ( // RQ19
        $past(!rst_n) |-> !fast_irq_request_q && !norm_irq_request_q && chan_pend_q == '0)
        else $error("outputs not cleared by reset");

    AST_NORM_ASSERTS: assert property ( // RQ18
        (act_norm != '0) |=> s_norm_shown)
        else $error("normal request missing while a normal channel is pending");

    AST_FAST_IDLE: assert property ( // RQ18
        (act_fast == '0) |=> !fast_irq_request_q)
        else $error("fast request without a pending fast channel");

    AST_NORM_INDEX: assert property ( // RQ6
        (act_norm != '0) |=> ((($past(act_norm) >> norm_irq_chan_q) & BIT0) != '0))
        else $error("normal index does not point at a pending normal channel");

    AST_FAST_LOWEST: assert property ( // RQ6
        s_fast_shown |-> ($past(act_fast) & ((BIT0 << fast_irq_chan_q) - BIT0)) == '0)
        else $error("a lower fast channel was pending but not chosen");

    AST_FAST_ENABLED: assert property ( // RQ3
        s_fast_shown |-> (($past(mask_q) >> fast_irq_chan_q) & BIT0) != '0)
        else $error("disabled channel reported as fast request");

    AST_NORM_ENABLED: assert property ( // RQ3
        s_norm_shown |-> (($past(mask_q) >> norm_irq_chan_q) & BIT0) != '0)
        else $error("disabled channel reported as normal request");

    AST_FAST_CLASS: assert property ( // RQ4
        s_fast_shown |-> (($past(class_q) >> fast_irq_chan_q) & BIT0) != '0)
        else $error("normal class channel reported on the fast output");

    AST_NORM_CLASS: assert property ( // RQ4
        s_norm_shown |-> (($past(class_q) >> norm_irq_chan_q) & BIT0) == '0)
        else $error("fast class channel reported on the normal output");

    AST_MASK_WRITE: assert property ( // RQ3
        mask_wr_en |=> chan_enable_q == $past(mask_wr_data))
        else $error("enable write not stored");

    AST_CLASS_WRITE: assert property ( // RQ4
        class_wr_en |=> chan_fast_q == $past(class_wr_data))
        else $error("class write not stored");

    AST_CFG_HOLD: assert property ( // RQ3
        s_quiet_cfg |=> $stable(mask_q) && $stable(class_q))
        else $error("enables or classes changed without a write");

    AST_FAST_IDLE_CHAN: assert property ( // RQ18
        !fast_irq_request_q |-> fast_irq_chan_q == CH_RST)
        else $error("fast index not at rest value while idle");

    AST_NORM_IDLE_CHAN: assert property ( // RQ18
        !norm_irq_request_q |-> norm_irq_chan_q == CH_RST)
        else $error("normal index not at rest value while idle");

    AST_MAP_READ: assert property ( // RQ1
        $past(rst_n) |-> map_rd_chan_q == $past(map_q[map_rd_src]))
        else $error("mapping readback does not match stored channel");

    AST_SW_TRIG_PEND: assert property ( // RQ9
        req_q[CH_SW_TRIG] |=> chan_pend_q[$past(map_q[CH_SW_TRIG])])
        else $error("software-triggered request did not raise its channel");

    AST_ESU_LOW_PEND: assert property ( // RQ9
        req_q[CH_ESU_LOW] |=> chan_pend_q[$past(map_q[CH_ESU_LOW])])
        else $error("error unit low-level request did not raise its channel");

endmodule

// *** bench/vip_core_model.sv ***
// processor core stand-in: takes the fast request before the normal one
// assumes the prioritizer outputs arrive registered on ref_clk
`timescale 1ns/10ps
module vip_core_model
    import vip_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    // requests from the prioritizer
    input  wire logic            fast_req,
    input  wire logic [CH_W-1:0] fast_chan,
    input  wire logic            norm_req,
    input  wire logic [CH_W-1:0] norm_chan,
    // channel the core is serving
    output logic      [CH_W-1:0] taken_chan_q
);
    logic [CH_W-1:0] taken_chan_d;
    // non-maskable handling would live in the core's own control register
    always_comb
    begin
        taken_chan_d = norm_req ? norm_chan : 6'h00;
        if (fast_req)
        begin
            taken_chan_d = fast_chan;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        taken_chan_q <= rst_n ? taken_chan_d : 6'h00;
    end
endmodule

// *** bench/vip_top_tb.sv ***
// self-checking bench: vip_top against an integer model of the channel logic
// assumes vip_pkg and vip_core_model are compiled first
`timescale 1ns/10ps
module vip_top_tb import vip_pkg::*;;
    logic ref_clk = 0, rst_n = 0, map_wr_en = 0, mask_wr_en = 0, class_wr_en = 0;
    logic fast_irq_request_q, norm_irq_request_q;
    logic [CH_W-1:0] map_wr_src = 0, map_wr_chan = 0, map_rd_src = 0;
    logic [CH_W-1:0] map_rd_chan_q, fast_irq_chan_q, norm_irq_chan_q, taken_chan_q;
    logic [NUM_CH-1:0] src_req = 0, mask_wr_data = 0, class_wr_data = 0;
    logic [NUM_CH-1:0] chan_enable_q, chan_fast_q, chan_pend_q, en_m = 0, fast_m = 0;
    logic [31:0] rng = 32'h8991_3324;
    int failures = 0, compares = 0;
    int map_m[NUM_CH];
    vip_top u_dut (.ref_clk, .rst_n, .src_req, .map_wr_en, .map_wr_src, .map_wr_chan, .map_rd_src,
        .map_rd_chan_q, .mask_wr_en, .mask_wr_data, .class_wr_en, .class_wr_data, .chan_enable_q,
        .chan_fast_q, .chan_pend_q, .fast_irq_request_q, .fast_irq_chan_q, .norm_irq_request_q,
        .norm_irq_chan_q);
    vip_core_model u_core (.ref_clk, .rst_n, .fast_req(fast_irq_request_q), .fast_chan(fast_irq_chan_q),
        .norm_req(norm_irq_request_q), .norm_chan(norm_irq_chan_q), .taken_chan_q);
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_all();
        logic [NUM_CH-1:0] pend;
        int qf[$];
        int qn[$];
        pend = '0;
        for (int s = 0; s < NUM_CH; s++) if (src_req[s]) pend[map_m[s]] = 1'b1;
        for (int c = NUM_CH - 1; c >= 0; c--)
            if (pend[c] && en_m[c]) if (fast_m[c]) qf.push_front(c); else qn.push_front(c);
        chk(chan_pend_q, pend, "pending");
        chk(chan_enable_q, en_m, "enables");
        chk(chan_fast_q, fast_m, "classes");
        chk(fast_irq_request_q, qf.size() != 0, "fast request");
        chk(fast_irq_chan_q, qf.size() ? qf[0] : 0, "fast channel");
        chk(norm_irq_request_q, qn.size() != 0, "normal request");
        chk(norm_irq_chan_q, qn.size() ? qn[0] : 0, "normal channel");
        chk(taken_chan_q, qf.size() ? qf[0] : (qn.size() ? qn[0] : 0), "core view");
    endtask
    task automatic step(logic [63:0] src, logic [63:0] en, logic [63:0] cls, int ms, int mc, bit mw);
        src_req = src;
        mask_wr_data = en;
        class_wr_data = cls;
        map_wr_src = ms[CH_W-1:0];
        map_wr_chan = mc[CH_W-1:0];
        {mask_wr_en, class_wr_en, map_wr_en} = {2'b11, mw};
        en_m = en;
        fast_m = cls;
        if (mw) map_m[ms] = mc;
        cyc(1);
        {mask_wr_en, class_wr_en, map_wr_en} = 3'b000;
        cyc(3);
        check_all();
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < NUM_CH; i++) map_m[i] = i;
        cyc(10);
        rst_n = 1;
        cyc(1);
        check_all();
        for (int s = 0; s < NUM_CH; s++)
        begin
            map_rd_src = s[CH_W-1:0];
            cyc(2);
            chk(map_rd_chan_q, s, "default map");
        end
        $display("test reset and default map done");
        step(64'h1 << 40, '1, '0, 40, 3, 1);
        step((64'h1 << 40) | 64'h8, '1, 64'h8, 0, 0, 0);
        step(64'h3, 64'h2, 64'h1, 1, 1, 0);
        $display("test shared channel and mask done");
        for (int c = NUM_CH - 1; c >= 0; c--) step('1 << c, '1, '0, 0, 0, 0);
        $display("test priority walk done");
        repeat (300)
            step({xs(), xs()} & {xs(), xs()} & {xs(), xs()}, {xs(), xs()}, {xs(), xs()},
                 xs() % NUM_CH, xs() % NUM_CH, xs() & 1);
        $display("test random traffic done");
        close_out();
    end
endmodule
